// ### inc/dma_pkg.sv
/*
  constants, types and field layout for the four-channel transfer
  controller register set.
  assumes a single system clock and a longword-wide register port.
*/
package dma_pkg;

  localparam int NUM_CH  = 4;
  localparam int COUNT_W = 24;

  // register window: byte address = REG_BASE + ch*16 + sel*4
  localparam logic [7:0] REG_BASE = 8'h20;
  localparam logic [7:0] REG_TOP  = 8'h60;
  localparam logic [1:0] SEL_SRC  = 2'h0;
  localparam logic [1:0] SEL_DST  = 2'h1;
  localparam logic [1:0] SEL_CNT  = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;

  // control register field positions
  localparam int BIT_INDIRECT    = 20;
  localparam int BIT_RELOAD      = 19;
  localparam int BIT_REQ_ACK_POL = 18;
  localparam int BIT_ACK_TIMING  = 17;
  localparam int BIT_ACK_POL     = 16;
  localparam int POS_DST_MODE    = 14;
  localparam int POS_SRC_MODE    = 12;
  localparam int POS_REQ_SRC     = 8;
  localparam int BIT_REQ_SENSE   = 6;
  localparam int BIT_BUS_MODE    = 5;
  localparam int POS_UNIT_SIZE   = 3;
  localparam int BIT_IRQ_EN      = 2;
  localparam int BIT_DONE        = 1;
  localparam int BIT_ENABLE      = 0;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // software-writable bits per channel; the done flag is handled apart
  localparam logic [31:0] WMASK_CH01 = 32'h0007_ff7d;
  localparam logic [31:0] WMASK_CH2  = 32'h0008_ff3d;
  localparam logic [31:0] WMASK_CH3  = 32'h0010_ff3d;

  localparam logic [1:0] SZ_BYTE   = 2'h0;
  localparam logic [1:0] SZ_WORD   = 2'h1;
  localparam logic [1:0] SZ_LONG   = 2'h2;
  localparam logic [1:0] SZ_UNIT16 = 2'h3;

  localparam logic [1:0] STEP_FIXED = 2'h0;
  localparam logic [1:0] STEP_INC   = 2'h1;
  localparam logic [1:0] STEP_DEC   = 2'h2;

  localparam logic [3:0] RS_SGL_RD = 4'h2;
  localparam logic [3:0] RS_SGL_WR = 4'h3;
  localparam logic [3:0] RS_AUTO   = 4'h4;

  localparam logic [1:0] UNIT_LAST_BEAT = 2'h3;
  localparam logic [1:0] RELOAD_LAST    = 2'h3;
  localparam int         RELOAD_CH      = 2;
  localparam int         INDIRECT_CH    = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WR   = 2'b11,
    ST_IND  = 2'b10
  } state_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_t;

endpackage

// ### hdl/dma_channel_regs.sv
/*
  four-channel transfer controller: address, count and control registers
  with the engine that steps them, plus the channel 0 pin handshake.
  assumes a memory port that answers each request with a one-cycle ack
  and a register master that never issues read and write together.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - source register shows next source address
// - destination register shows next destination address
// - address and count registers unreset, held
// - count of zero means 16777216 transfers
// - count decrements to show remaining transfers
// - one decrement per 16-byte unit
// - count bits 31..24 read zero
// - control bits 31..21 and 7 read zero
// - bit 20 only ch3, bit 19 only ch2
// - bits 6, 16..18 absent in ch2, ch3
// - control clears on reset, held in standby
// - done flag cleared by zero after one-read
// - ch3 indirect select uses source as pointer
// - ch2 reload restores initial source address
// - request accepted output polarity select
// - ack strobe in read or write cycle
// - ack strobe polarity select
// - destination step fixed, increment, decrement
// - reload after every four transfers
// - unit size; 16-byte unit is four longwords
module dma_channel_regs (
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire logic             standby_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_we_i,
  input  wire logic             reg_re_i,
  output logic      [31:0]      reg_rdata_o,
  input  wire logic [3:0]       periph_req_i,
  input  wire logic             transfer_request_in_n_i,
  output dma_pkg::mem_cmd_t     mem_o,
  input  wire logic [31:0]      mem_rdata_i,
  input  wire logic             mem_ack_i,
  output logic                  transfer_ack_strobe_o,
  output logic                  request_accepted_out_o
);

  function automatic logic [31:0] step_delta(input logic [1:0] mode,
                                             input logic [1:0] size);
    logic [31:0] mag;
    mag = (size == dma_pkg::SZ_BYTE) ? 32'h1 :
          (size == dma_pkg::SZ_WORD) ? 32'h2 : 32'h4;
    case (mode)
      dma_pkg::STEP_INC: step_delta = mag;
      dma_pkg::STEP_DEC: step_delta = 32'h0 - mag;
      default:           step_delta = 32'h0;
    endcase
  endfunction

  function automatic logic [1:0] bus_size(input logic [1:0] size);
    bus_size = (size == dma_pkg::SZ_UNIT16) ? dma_pkg::SZ_LONG : size;
  endfunction

  function automatic logic [31:0] wmask(input int ch);
    case (ch)
      2:       wmask = dma_pkg::WMASK_CH2;
      3:       wmask = dma_pkg::WMASK_CH3;
      default: wmask = dma_pkg::WMASK_CH01;
    endcase
  endfunction

  logic [31:0]  src_addr_q [4];
  logic [31:0]  src_d      [4];
  logic [31:0]  dst_addr_q [4];
  logic [31:0]  dst_d      [4];
  logic [23:0]  count_q    [4];
  logic [23:0]  count_d    [4];
  logic [31:0]  ctrl_q     [4];
  logic [31:0]  ctrl_d     [4];
  logic [3:0]   armed_q;
  logic [31:0]  reload_base_q;
  logic [1:0]   reload_cnt_q;
  dma_pkg::state_t state_q, state_d;
  logic [1:0]   chan_q, chan_d;
  logic [1:0]   beat_q, beat_d;
  logic [31:0]  data_q, data_d;
  dma_pkg::mem_cmd_t mem_q, mem_d;
  logic         ack_q, reqacc_q;
  logic [31:0]  rdata_q;
  logic         pin_s1_q, pin_s2_q, pin_s3_q, pend_q;

  // register port decode
  wire          reg_hit  = (reg_addr_i >= dma_pkg::REG_BASE) &&
                           (reg_addr_i < dma_pkg::REG_TOP) &&
                           (reg_addr_i[1:0] == 2'h0);
  wire [3:0]    ch_raw   = reg_addr_i[7:4] - dma_pkg::REG_BASE[7:4];
  wire [1:0]    reg_ch   = ch_raw[1:0];
  wire [1:0]    reg_sel  = reg_addr_i[3:2];
  wire          wr_hit   = reg_we_i && reg_hit;
  wire          rd_hit   = reg_re_i && reg_hit;
  wire          wr_ctrl  = wr_hit && (reg_sel == dma_pkg::SEL_CTRL);

  // request sensing: low level or falling edge on the synced pin
  wire          pin_fall = pin_s3_q && !pin_s2_q;
  wire          pin_req  = ctrl_q[0][dma_pkg::BIT_REQ_SENSE] ?
                           pend_q : !pin_s2_q;

  logic [3:0] req_vec;
  always_comb begin
    for (int c = 0; c < dma_pkg::NUM_CH; c++) begin
      logic [3:0] rsrc;
      rsrc = ctrl_q[c][dma_pkg::POS_REQ_SRC +: 4];
      req_vec[c] = ctrl_q[c][dma_pkg::BIT_ENABLE] &&
                   !ctrl_q[c][dma_pkg::BIT_DONE] &&
                   ((c == 0 && rsrc[3:2] == 2'h0) ? pin_req :
                    (rsrc == dma_pkg::RS_AUTO) ? 1'b1 : periph_req_i[c]);
    end
  end

  // fixed priority, channel 0 first
  wire [1:0] grant_ch = req_vec[0] ? 2'h0 : req_vec[1] ? 2'h1 :
                        req_vec[2] ? 2'h2 : 2'h3;
  wire       at_rest  = (state_q == dma_pkg::ST_IDLE) && (beat_q == 2'h0);
  wire       grant    = at_rest && (|req_vec) && !standby_i;
  wire [1:0] sel_ch   = at_rest ? grant_ch : chan_q;

  // controls of the channel being served
  wire [31:0] ctrl_a   = ctrl_q[sel_ch];
  wire [1:0]  size_a   = ctrl_a[dma_pkg::POS_UNIT_SIZE +: 2];
  wire [3:0]  rsrc_a   = ctrl_a[dma_pkg::POS_REQ_SRC +: 4];
  wire        ext0     = (sel_ch == 2'h0) && (rsrc_a[3:2] == 2'h0);
  wire        sgl_rd   = ext0 && (rsrc_a == dma_pkg::RS_SGL_RD);
  wire        sgl_wr   = ext0 && (rsrc_a == dma_pkg::RS_SGL_WR);
  wire        ind_a    = (sel_ch == 2'(dma_pkg::INDIRECT_CH)) &&
                         ctrl_a[dma_pkg::BIT_INDIRECT];
  wire        unit16   = (size_a == dma_pkg::SZ_UNIT16);
  wire        go       = grant || (state_q == dma_pkg::ST_IDLE &&
                                   beat_q != 2'h0);
  logic       beat_done;
  wire        unit_done = beat_done &&
                          (!unit16 || beat_q == dma_pkg::UNIT_LAST_BEAT);

  always_comb begin
    state_d   = state_q;
    chan_d    = chan_q;
    beat_d    = beat_q;
    data_d    = data_q;
    mem_d     = mem_q;
    beat_done = 1'b0;
    case (state_q)
      dma_pkg::ST_IDLE: begin
        if (go) begin
          chan_d = sel_ch;
          if (ind_a) begin
            // pointer fetch is always a longword
            state_d = dma_pkg::ST_IND;
            mem_d = '{1'b1, 1'b0, dma_pkg::SZ_LONG, src_addr_q[sel_ch],
                      32'h0};
          end else if (sgl_wr) begin
            state_d = dma_pkg::ST_WR;
            mem_d = '{1'b1, 1'b1, bus_size(size_a), dst_addr_q[sel_ch],
                      32'h0};
          end else begin
            state_d = dma_pkg::ST_RD;
            mem_d = '{1'b1, 1'b0, bus_size(size_a), src_addr_q[sel_ch],
                      32'h0};
          end
        end
      end
      dma_pkg::ST_IND: begin
        if (mem_ack_i) begin
          state_d = dma_pkg::ST_RD;
          mem_d = '{1'b1, 1'b0, bus_size(size_a), mem_rdata_i,
                    32'h0};
        end
      end
      dma_pkg::ST_RD: begin
        if (mem_ack_i) begin
          data_d = mem_rdata_i;
          if (sgl_rd) begin
            beat_done = 1'b1;
            state_d   = dma_pkg::ST_IDLE;
            mem_d.req = 1'b0;
          end else begin
            state_d = dma_pkg::ST_WR;
            mem_d = '{1'b1, 1'b1, bus_size(size_a), dst_addr_q[chan_q],
                      mem_rdata_i};
          end
        end
      end
      dma_pkg::ST_WR: begin
        if (mem_ack_i) begin
          beat_done = 1'b1;
          state_d   = dma_pkg::ST_IDLE;
          mem_d.req = 1'b0;
        end
      end
      default: begin
        state_d   = dma_pkg::ST_IDLE;
        mem_d.req = 1'b0;
      end
    endcase
    // a 16-byte unit is four longword beats on one channel
    if (beat_done) begin
      beat_d = (unit16 && beat_q != dma_pkg::UNIT_LAST_BEAT) ?
               beat_q + 2'h1 : 2'h0;
    end
  end

  // register next values: engine stepping first, software write next, done-flag completion last
  always_comb begin
    for (int c = 0; c < dma_pkg::NUM_CH; c++) begin
      logic here;
      here     = (chan_q == 2'(c));
      src_d[c] = src_addr_q[c];
      dst_d[c] = dst_addr_q[c];
      count_d[c] = count_q[c];
      ctrl_d[c]  = ctrl_q[c];
      if (beat_done && here) begin
        if (!sgl_wr) begin
          src_d[c] = src_addr_q[c] + step_delta(
            ctrl_q[c][dma_pkg::POS_SRC_MODE +: 2],
            ind_a ? dma_pkg::SZ_LONG : size_a);
        end
        if (!sgl_rd) begin
          dst_d[c] = dst_addr_q[c] + step_delta(
            ctrl_q[c][dma_pkg::POS_DST_MODE +: 2], size_a);
        end
      end
      if (unit_done && here) begin
        // zero wraps to all ones, giving the full 2^24 run
        count_d[c] = count_q[c] - 24'h1;
        if (c == dma_pkg::RELOAD_CH && ctrl_q[c][dma_pkg::BIT_RELOAD] &&
            reload_cnt_q == dma_pkg::RELOAD_LAST) begin
          src_d[c] = reload_base_q;
        end
      end
      if (wr_hit && reg_ch == 2'(c)) begin
        case (reg_sel)
          dma_pkg::SEL_SRC: src_d[c] = reg_wdata_i;
          dma_pkg::SEL_DST: dst_d[c] = reg_wdata_i;
          dma_pkg::SEL_CNT: count_d[c] = reg_wdata_i[23:0];
          default: ctrl_d[c] = (reg_wdata_i & wmask(c)) |
                               (ctrl_q[c] & ~wmask(c));
        endcase
      end
      if (wr_ctrl && reg_ch == 2'(c) && armed_q[c] &&
          !reg_wdata_i[dma_pkg::BIT_DONE]) begin
        ctrl_d[c][dma_pkg::BIT_DONE] = 1'b0;
      end
      // a completion in the clearing cycle wins
      if (unit_done && here && count_q[c] == 24'h1) begin
        ctrl_d[c][dma_pkg::BIT_DONE] = 1'b1;
      end
    end
  end

  // address and count have no reset; standby only blocks new grants, so a unit already started runs to its end
  always_ff @(posedge clk_sys_i) begin
    src_addr_q <= src_d;
    dst_addr_q <= dst_d;
    count_q    <= count_d;
    if (wr_hit && reg_ch == 2'(dma_pkg::RELOAD_CH) &&
        reg_sel == dma_pkg::SEL_SRC) begin
      reload_base_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int c = 0; c < dma_pkg::NUM_CH; c++) begin
        ctrl_q[c] <= dma_pkg::CTRL_RESET;
      end
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // the clear is honoured only after a read has shown the flag set
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed_q <= 4'h0;
    end else begin
      for (int c = 0; c < dma_pkg::NUM_CH; c++) begin
        if (wr_ctrl && reg_ch == 2'(c)) begin
          armed_q[c] <= 1'b0;
        end else if (rd_hit && reg_sel == dma_pkg::SEL_CTRL &&
                     reg_ch == 2'(c)) begin
          armed_q[c] <= ctrl_q[c][dma_pkg::BIT_DONE];
        end
      end
    end
  end

  wire src2_wr = wr_hit && reg_ch == 2'(dma_pkg::RELOAD_CH) &&
                 reg_sel == dma_pkg::SEL_SRC;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reload_cnt_q <= 2'h0;
    end else if (src2_wr) begin
      reload_cnt_q <= 2'h0;
    end else if (unit_done && chan_q == 2'(dma_pkg::RELOAD_CH)) begin
      reload_cnt_q <= reload_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= dma_pkg::ST_IDLE;
      chan_q  <= 2'h0;
      beat_q  <= 2'h0;
      data_q  <= 32'h0;
      mem_q   <= '0;
    end else begin
      state_q <= state_d;
      chan_q  <= chan_d;
      beat_q  <= beat_d;
      data_q  <= data_d;
      mem_q   <= mem_d;
    end
  end

  // pin synchroniser; only the second and third stages feed logic
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
      pend_q   <= 1'b0;
    end else begin
      pin_s1_q <= transfer_request_in_n_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_fall) begin
        pend_q <= 1'b1;
      end else if (grant && grant_ch == 2'h0) begin
        pend_q <= 1'b0;
      end
    end
  end

  // pin strobes; reset leaves both inactive for the low-active default
  wire ack_act = ext0 && (state_d != dma_pkg::ST_IDLE) &&
                 (sgl_rd || sgl_wr ||
                  (state_d == dma_pkg::ST_RD &&
                   !ctrl_q[0][dma_pkg::BIT_ACK_TIMING]) ||
                  (state_d == dma_pkg::ST_WR &&
                   ctrl_q[0][dma_pkg::BIT_ACK_TIMING]));
  wire reqacc_act = grant && ext0;
  wire pol_ack    = ctrl_q[0][dma_pkg::BIT_ACK_POL];
  wire pol_reqacc = ctrl_q[0][dma_pkg::BIT_REQ_ACK_POL];

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q    <= 1'b1;
      reqacc_q <= 1'b1;
    end else begin
      ack_q    <= pol_ack ? ack_act : !ack_act;
      reqacc_q <= pol_reqacc ? reqacc_act : !reqacc_act;
    end
  end

  // read mux; unmapped reads and idle cycles return zero
  wire [31:0] rd_val = (reg_sel == dma_pkg::SEL_SRC) ? src_addr_q[reg_ch] :
                       (reg_sel == dma_pkg::SEL_DST) ? dst_addr_q[reg_ch] :
                       (reg_sel == dma_pkg::SEL_CNT) ?
                       {8'h00, count_q[reg_ch]} : ctrl_q[reg_ch];
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rd_hit ? rd_val : 32'h0;
    end
  end

  assign reg_rdata_o            = rdata_q;
  assign mem_o                  = mem_q;
  assign transfer_ack_strobe_o  = ack_q;
  assign request_accepted_out_o = reqacc_q;

  // checks
  wire [23:0] cnt_cur = count_q[chan_q];
  wire [31:0] dst_cur = dst_addr_q[chan_q];
  wire [31:0] src_cur = src_addr_q[chan_q];
  wire        sw_busy = wr_hit && reg_ch == chan_q;
  wire [31:0] src_ch2 = src_addr_q[2];

  a_count_top_zero: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) rd_hit && reg_sel == dma_pkg::SEL_CNT
    |=> reg_rdata_o[31:24] == 8'h00)
    else $error("count upper byte not zero");
  a_ctrl_rsvd_zero: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) rd_hit && reg_sel == dma_pkg::SEL_CTRL
    |=> reg_rdata_o[31:21] == 11'h000 && !reg_rdata_o[7])
    else $error("reserved control bits not zero");
  a_ch_bits_single: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) ctrl_q[0][20:19] == 2'h0 &&
    ctrl_q[1][20:19] == 2'h0 && !ctrl_q[2][20] && !ctrl_q[3][19])
    else $error("channel-specific bit set in wrong channel");
  a_ch23_pin_bits: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) ctrl_q[2][18:16] == 3'h0 && !ctrl_q[2][6] &&
    ctrl_q[3][18:16] == 3'h0 && !ctrl_q[3][6])
    else $error("pin control bit stored in channel 2 or 3");
  a_done_write_one: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) wr_ctrl && reg_wdata_i[1] &&
    !ctrl_q[reg_ch][1] && !(unit_done && chan_q == reg_ch)
    |=> !ctrl_q[$past(reg_ch)][1])
    else $error("writing one set the done flag");
  a_count_step: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) unit_done && !sw_busy
    |=> cnt_cur == $past(cnt_cur) - 24'h1)
    else $error("count did not drop by one per unit");
  a_unit_four_beat: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) beat_done && unit16 && beat_q != 2'h3
    |-> !unit_done ##1 beat_q == $past(beat_q) + 2'h1)
    else $error("16-byte unit counted before fourth beat");
  a_dst_inc_long: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) beat_done && !sgl_rd && !sw_busy &&
    ctrl_a[15:14] == dma_pkg::STEP_INC && size_a == dma_pkg::SZ_LONG
    |=> dst_cur == $past(dst_cur) + 32'h4)
    else $error("destination did not advance by four");
  a_src_inc_byte: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) beat_done && !sgl_wr && !sw_busy && !ind_a &&
    chan_q != 2'h2 &&
    ctrl_a[13:12] == dma_pkg::STEP_INC && size_a == dma_pkg::SZ_BYTE
    |=> src_cur == $past(src_cur) + 32'h1)
    else $error("source did not advance by one");
  a_reload_four: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) unit_done && chan_q == 2'h2 && !src2_wr &&
    ctrl_q[2][19] && reload_cnt_q == 2'h3
    |=> src_ch2 == $past(reload_base_q))
    else $error("source not reloaded after four transfers");
  a_reqacc_pulse: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) reqacc_act && $stable(pol_reqacc)
    |=> request_accepted_out_o == $past(pol_reqacc))
    else $error("request accepted output wrong level");

endmodule // dma_channel_regs

// ### dv/dma_far_model.sv
/*
  far side model: memory that answers the engine's requests, and the
  channel 0 peripheral that drives the request pin.
  assumes req stands until the edge that takes ack.
*/
`timescale 1ns/1ps
module dma_far_model (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire dma_pkg::mem_cmd_t mem_i,
  input  wire logic              want_i,
  output logic                   req_n_o,
  output logic                   ack_o,
  output logic [31:0]            rdata_o,
  output logic [31:0]            rd_addr_o,
  output logic [15:0]            beats_o
);
  logic [1:0] wait_q;
  logic       slow_q;

  // pin is driven as the inverse of want_i, so it idles high
  assign req_n_o = ~want_i;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {ack_o, wait_q, slow_q, rd_addr_o, beats_o} <= '0;
      rdata_o <= 32'h0;
    end else begin
      ack_o <= 1'b0;
      // never leave stale read data standing between answers
      rdata_o <= ~rdata_o;
      if (ack_o) begin
        wait_q <= 2'h0;
      end else if (mem_i.req) begin
        if (wait_q == (slow_q ? 2'h3 : 2'h1)) begin
          ack_o <= 1'b1;
          // alternate prompt and slow answers
          slow_q <= ~slow_q;
          beats_o <= beats_o + 16'h1;
          if (!mem_i.wr) begin
            rd_addr_o <= mem_i.addr;
            rdata_o <= mem_i.addr + 32'h1000_0000;
          end
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule // dma_far_model

// ### dv/dma_channel_address_count_control_tb_top.sv
/*
  testbench for the transfer controller register set.
  assumes the far model answers memory beats and drives the pin.
*/
`timescale 1ns/1ps
module dma_channel_address_count_control_tb_top;
  logic              clk_sys_i, nrst_i, standby, we, re, want, req_n;
  logic              ack, transfer_ack_strobe, request_accepted_out;
  logic [7:0]        addr;
  logic [3:0]        preq;
  logic [15:0]       beats;
  logic [31:0]       wdata, rdata, mrdata, rd_addr, d, m;
  dma_pkg::mem_cmd_t mem;
  int                errors, total_checks, acc_n, ack_rd, ack_wr;

  always #12.5 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i) begin
    if (request_accepted_out === 1'b1) acc_n++;
    if (transfer_ack_strobe === 1'b1 && mem.req === 1'b1 && mem.wr === 1'b1) ack_wr++;
    if (transfer_ack_strobe === 1'b1 && mem.req === 1'b1 && mem.wr === 1'b0) ack_rd++;
  end

  dma_channel_regs i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .standby_i(standby), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .periph_req_i(preq), .transfer_request_in_n_i(req_n), .mem_o(mem),
    .mem_rdata_i(mrdata), .mem_ack_i(ack), .transfer_ack_strobe_o(transfer_ack_strobe),
    .request_accepted_out_o(request_accepted_out));

  dma_far_model i_far (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .mem_i(mem), .want_i(want), .req_n_o(req_n), .ack_o(ack),
    .rdata_o(mrdata), .rd_addr_o(rd_addr), .beats_o(beats));

  function automatic logic [7:0] ra(input int ch, input int sel);
    return dma_pkg::REG_BASE + 8'(ch * 16 + sel * 4);
  endfunction

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk_sys_i);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_sys_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask

  // program, run to completion, check the stepped registers
  task automatic run(input int ch, input logic [31:0] c, s, t,
                     input logic [23:0] n, input logic [31:0] es, et,
                     input logic [15:0] nb, input logic sb);
    logic [15:0] b0;
    int          k;
    b0 = beats;
    standby <= sb;
    wr(ra(ch, 0), s);
    wr(ra(ch, 1), t);
    wr(ra(ch, 2), {8'h0, n});
    wr(ra(ch, 3), c);
    if (sb) begin
      repeat (20) @(posedge clk_sys_i);
      rchk(ra(ch, 2), {8'h0, n});
      standby <= 1'b0;
    end
    k = 0;
    do begin
      rd(ra(ch, 3));
      k++;
    end while (d[1] !== 1'b1 && k < 400);
    if (k >= 400) begin
      errors++;
      end_sim();
    end
    chk(d, c | 32'h2);
    chk({16'h0, beats - b0}, {16'h0, nb});
    rchk(ra(ch, 0), es);
    rchk(ra(ch, 1), et);
    rchk(ra(ch, 2), 32'h0);
    if (sb) begin
      wr(ra(ch, 3), c | 32'h2);
      wr(ra(ch, 3), c & ~32'h1);
      rchk(ra(ch, 3), (c & ~32'h1) | 32'h2);
      rd(ra(ch, 3));
    end
    wr(ra(ch, 3), c & ~32'h1);
    rchk(ra(ch, 3), c & ~32'h1);
  endtask

  initial begin
    {clk_sys_i, nrst_i, standby, we, re, want} = '0;
    {addr, preq, wdata} = '0;
    {errors, total_checks, acc_n, ack_rd, ack_wr} = '0;
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (int ch = 0; ch < 4; ch++) begin
      rchk(ra(ch, 3), dma_pkg::CTRL_RESET);
      // the done flag is written as one too and must stay clear
      wr(ra(ch, 3), 32'hffff_ffff);
      rchk(ra(ch, 3), ch < 2 ? dma_pkg::WMASK_CH01 : ch == 2 ?
           dma_pkg::WMASK_CH2 : dma_pkg::WMASK_CH3);
      wr(ra(ch, 3), 32'h0);
    end
    wr(ra(1, 2), 32'hffff_ffff);
    rchk(ra(1, 2), 32'h00ff_ffff);
    rchk(8'h60, 32'h0);
    preq <= 4'b0010;
    // every address below is aligned to its unit
    run(1, 32'h5411, 32'h100, 32'h200, 24'd2, 32'h108, 32'h208, 16'd4,
        1'b1);
    run(1, 32'h5419, 32'h400, 32'h800, 24'd1, 32'h410, 32'h810, 16'd8,
        1'b0);
    run(1, 32'h8c09, 32'h100, 32'h300, 24'd3, 32'h100, 32'h2fa, 16'd6,
        1'b0);
    run(1, 32'h5401, 32'h100, 32'h200, 24'd2, 32'h102, 32'h202, 16'd4,
        1'b0);
    run(2, 32'h85411, 32'h1000, 32'h2000, 24'd6, 32'h1008, 32'h2018,
        16'd12, 1'b0);
    run(3, 32'h105411, 32'h40, 32'h3000, 24'd1, 32'h44, 32'h3004,
        16'd3, 1'b0);
    chk(rd_addr, 32'h1000_0040);
    want <= 1'b1;
    // pass 0 strobes the read cycle, 1 the write cycle, 2 single read
    for (int am = 0; am < 3; am++) begin
      m = (am == 1) ? 32'h2_0000 : (am == 2) ? 32'h200 : 32'h0;
      wr(ra(0, 3), 32'h50010 | m);
      repeat (3) @(posedge clk_sys_i);
      #1 {acc_n, ack_rd, ack_wr} = '0;
      run(0, 32'h55011 | m, 32'h500, 32'h600, 24'd1, 32'h504,
          (am == 2) ? 32'h600 : 32'h604, (am == 2) ? 16'd1 : 16'd2,
          1'b0);
      chk(32'(acc_n), 32'h1);
      chk(32'((am == 1) ? ack_rd : ack_wr), 32'h0);
      chk(32'(((am == 1) ? ack_wr : ack_rd) > 0), 32'h1);
    end
    end_sim();
  end

  // cut a hang short well inside the cycle budget
  initial begin
    #2_000_000;
    errors++;
    end_sim();
  end
endmodule // dma_channel_address_count_control_tb_top
